// ===== core/rtc_pkg.sv
// Constants for the retirement tagged-event counter.
// Assumes a 32-bit APB slave on pclk with word-aligned registers.
`default_nettype none
package rtc_pkg;
    // ======================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] REG_EVSEL  = 8'h00;
    localparam logic [7:0] REG_CCFG   = 8'h04;
    localparam logic [7:0] REG_UOPSEL = 8'h08;
    localparam logic [7:0] REG_SAMPEN = 8'h0c;
    localparam logic [7:0] REG_MATRIX = 8'h10;
    localparam logic [7:0] REG_COUNT  = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [31:0] RST_VAL   = 32'h0;
    // ======================================================
    // Event selector and counter configuration fields
    localparam int EVSEL_CODE_LSB = 25;
    localparam int EVSEL_MASK_LSB = 9;
    localparam int CCFG_SEL_LSB   = 13;
    localparam int CCFG_EN_BIT    = 12;
    localparam logic [6:0] EVT_COMPLETED = 7'h07;
    localparam logic [6:0] EVT_FRONT_END = 7'h08;
    localparam logic [6:0] EVT_EXEC      = 7'h0c;
    localparam logic [6:0] EVT_REPLAY    = 7'h09;
    localparam logic [2:0] CCFG_COMPLETED = 3'h4;
    localparam logic [2:0] CCFG_TAGGED    = 3'h5;
    localparam int MASK_NONSPEC = 0;
    localparam int MASK_SPEC    = 1;
    // ======================================================
    // Upstream selector fields
    localparam int UOP_LOAD_TAG  = 10;
    localparam int UOP_STORE_TAG = 11;
    localparam int UOP_ALL_TYPES = 24;
    localparam int UOP_TAG_EN    = 4;
    localparam int UOP_TAG_LSB   = 5;
    localparam logic [3:0] TAG_VALUE_ONE = 4'h1;
    // ======================================================
    // Sampling enable and vertical matrix bits
    localparam int SE_L1    = 0;
    localparam int SE_L2    = 1;
    localparam int SE_DTLB  = 2;
    localparam int SE_FWD   = 9;
    localparam int SE_SPLIT = 10;
    localparam int SE_BR0   = 15;
    localparam int SE_BR1   = 16;
    localparam int SE_EN0   = 24;
    localparam int SE_EN1   = 25;
    localparam int MX_LOAD   = 0;
    localparam int MX_STORE  = 1;
    localparam int MX_BRANCH = 4;
    // ======================================================
    // Per-slot replay cause vector
    localparam int CAUSE_W    = 6;
    localparam int CS_L1      = 0;
    localparam int CS_L2      = 1;
    localparam int CS_DTLB    = 2;
    localparam int CS_FWD     = 3;
    localparam int CS_SPLIT   = 4;
    localparam int CS_MISPRED = 5;
    typedef enum logic [1:0] {
        RTC_IDLE  = 2'b00,
        RTC_SETUP = 2'b01,
        RTC_ACC   = 2'b11
    } rtc_bus_t;
endpackage
`default_nettype wire

// ===== core/rtc_retire_count.sv
// Retirement event counter with front-end, execution and replay tagging.
// Assumes retirement slot signals come from core logic on pclk.
// What this block does
// - Event code 07H with configuration select 04H counts retiring instructions, mask bit 0 non-speculative and bit 1 speculative.
// - The completed event counts retired completions, not starts, and never raises a precise sample.
// - With the load or store tag bit set, loads or stores are tagged and the front-end event counts tagged non-speculative ones.
// - The front-end count may fall short while the floating-point stack overflows or underflows.
// - Execution tagging needs all-types, tag-enable and tag value 1; mask bit 0 counts the tagged non-speculative ones.
// - Replay tags count only with sampling bits 24 and 25 plus a matching cause bit (0,1,2,9,10, or 15 and 16).
// - Untaggable operations (I/O, uncached, locked, returns, far transfers) are never replay-tagged.
`default_nettype none
module rtc_retire_count #(
    parameter int SLOTS = 3
) (
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [7:0]                        paddr,
    input  wire logic [31:0]                       pwdata,
    output logic      [31:0]                       prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    input  wire logic [SLOTS-1:0]                  ret_valid,
    input  wire logic [SLOTS-1:0]                  ret_spec,
    input  wire logic [SLOTS-1:0]                  ret_load,
    input  wire logic [SLOTS-1:0]                  ret_store,
    input  wire logic [SLOTS-1:0]                  ret_branch,
    input  wire logic [SLOTS-1:0]                  ret_no_tag,
    input  wire logic [SLOTS-1:0]                  ret_exec_match,
    input  wire logic [SLOTS*rtc_pkg::CAUSE_W-1:0] ret_cause,
    input  wire logic                              fp_stack_fault,
    output logic      [3:0]                        evt_inc,
    output logic                                   precise_req
);
    // ======================================================
    // State
    typedef struct packed {
        rtc_pkg::rtc_bus_t bus;
        logic [31:0]       evsel;
        logic [31:0]       ccfg;
        logic [31:0]       uopsel;
        logic [31:0]       sampen;
        logic [31:0]       matrix;
        logic [31:0]       count;
        logic [31:0]       rdata;
        logic              ready;
        logic              err;
        logic [3:0]        inc;
        logic              precise;
    } rtc_state_t;

    rtc_state_t st_reg;
    rtc_state_t st_next;

    function automatic logic [3:0] rtc_popcount(input logic [SLOTS-1:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < SLOTS; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction

    function automatic logic rtc_mapped(input logic [7:0] a);
        return (a == rtc_pkg::REG_EVSEL) || (a == rtc_pkg::REG_CCFG) ||
               (a == rtc_pkg::REG_UOPSEL) || (a == rtc_pkg::REG_SAMPEN) ||
               (a == rtc_pkg::REG_MATRIX) || (a == rtc_pkg::REG_COUNT) ||
               (a == rtc_pkg::REG_STATUS);
    endfunction

    // ======================================================
    // Event decode
    logic [6:0]       ev_code;
    logic [15:0]      ev_mask;
    logic [2:0]       cc_sel;
    logic             cc_en;
    logic             mode_comp;
    logic             mode_fe;
    logic             mode_ex;
    logic             mode_rp;
    logic             ex_tag_on;
    localparam int CAUSE_W_L = rtc_pkg::CAUSE_W;
    logic             rp_armed;
    logic [CAUSE_W_L-1:0] cause_en;
    logic [SLOTS-1:0] comp_hit;
    logic [SLOTS-1:0] fe_hit;
    logic [SLOTS-1:0] ex_hit;
    logic [SLOTS-1:0] rp_hit;
    logic [SLOTS-1:0] nonspec;

    always_comb begin
        ev_code   = st_reg.evsel[rtc_pkg::EVSEL_CODE_LSB +: 7];
        ev_mask   = st_reg.evsel[rtc_pkg::EVSEL_MASK_LSB +: 16];
        cc_sel    = st_reg.ccfg[rtc_pkg::CCFG_SEL_LSB +: 3];
        cc_en     = st_reg.ccfg[rtc_pkg::CCFG_EN_BIT];
        mode_comp = cc_en && ev_code == rtc_pkg::EVT_COMPLETED &&
                    cc_sel == rtc_pkg::CCFG_COMPLETED;
        mode_fe   = cc_en && ev_code == rtc_pkg::EVT_FRONT_END &&
                    cc_sel == rtc_pkg::CCFG_TAGGED;
        mode_ex   = cc_en && ev_code == rtc_pkg::EVT_EXEC &&
                    cc_sel == rtc_pkg::CCFG_TAGGED;
        mode_rp   = cc_en && ev_code == rtc_pkg::EVT_REPLAY &&
                    cc_sel == rtc_pkg::CCFG_TAGGED;
        ex_tag_on = st_reg.uopsel[rtc_pkg::UOP_ALL_TYPES] &&
                    st_reg.uopsel[rtc_pkg::UOP_TAG_EN] &&
                    st_reg.uopsel[rtc_pkg::UOP_TAG_LSB +: 4] == rtc_pkg::TAG_VALUE_ONE;
        rp_armed  = st_reg.sampen[rtc_pkg::SE_EN0] && st_reg.sampen[rtc_pkg::SE_EN1];
        // Mispredict cause needs both of its enable bits
        cause_en = '0;
        cause_en[rtc_pkg::CS_L1]      = st_reg.sampen[rtc_pkg::SE_L1];
        cause_en[rtc_pkg::CS_L2]      = st_reg.sampen[rtc_pkg::SE_L2];
        cause_en[rtc_pkg::CS_DTLB]    = st_reg.sampen[rtc_pkg::SE_DTLB];
        cause_en[rtc_pkg::CS_FWD]     = st_reg.sampen[rtc_pkg::SE_FWD];
        cause_en[rtc_pkg::CS_SPLIT]   = st_reg.sampen[rtc_pkg::SE_SPLIT];
        cause_en[rtc_pkg::CS_MISPRED] = st_reg.sampen[rtc_pkg::SE_BR0] &&
                                        st_reg.sampen[rtc_pkg::SE_BR1];
        for (int i = 0; i < SLOTS; i++) begin
            nonspec[i]  = ret_valid[i] && !ret_spec[i];
            // Only retired slots are seen, so starts never count
            comp_hit[i] = ret_valid[i] &&
                          ((ev_mask[rtc_pkg::MASK_NONSPEC] && !ret_spec[i]) ||
                           (ev_mask[rtc_pkg::MASK_SPEC] && ret_spec[i]));
            fe_hit[i]   = nonspec[i] && ev_mask[rtc_pkg::MASK_NONSPEC] &&
                          ((st_reg.uopsel[rtc_pkg::UOP_LOAD_TAG] && ret_load[i]) ||
                           (st_reg.uopsel[rtc_pkg::UOP_STORE_TAG] && ret_store[i]));
            ex_hit[i]   = nonspec[i] && ev_mask[rtc_pkg::MASK_NONSPEC] &&
                          ex_tag_on && ret_exec_match[i];
            rp_hit[i]   = nonspec[i] && ev_mask[rtc_pkg::MASK_NONSPEC] && rp_armed &&
                          !ret_no_tag[i] &&
                          |(ret_cause[i*CAUSE_W_L +: CAUSE_W_L] & cause_en) &&
                          ((st_reg.matrix[rtc_pkg::MX_LOAD] && ret_load[i]) ||
                           (st_reg.matrix[rtc_pkg::MX_STORE] && ret_store[i]) ||
                           (st_reg.matrix[rtc_pkg::MX_BRANCH] && ret_branch[i]));
        end
    end

    // ======================================================
    // Next state: APB slave and counter
    logic [3:0] inc_now;
    logic       acc_done;

    always_comb begin
        st_next = st_reg;
        inc_now = 4'h0;
        // Tagged loads and stores are dropped while the stack faults
        if (mode_comp) begin
            inc_now = rtc_popcount(comp_hit);
        end else if (mode_fe && !fp_stack_fault) begin
            inc_now = rtc_popcount(fe_hit);
        end else if (mode_ex) begin
            inc_now = rtc_popcount(ex_hit);
        end else if (mode_rp) begin
            inc_now = rtc_popcount(rp_hit);
        end
        st_next.inc     = inc_now;
        st_next.precise = mode_rp && (|rp_hit);
        st_next.count   = st_reg.count + {28'h0, inc_now};
        acc_done        = psel && penable && st_reg.ready;
        st_next.ready   = 1'b0;
        st_next.err     = 1'b0;
        case (st_reg.bus)
            rtc_pkg::RTC_IDLE: begin
                if (psel && !penable) begin
                    st_next.bus = rtc_pkg::RTC_SETUP;
                end
            end
            rtc_pkg::RTC_SETUP: begin
                st_next.bus = rtc_pkg::RTC_ACC;
            end
            rtc_pkg::RTC_ACC: begin
                st_next.bus = rtc_pkg::RTC_IDLE;
            end
            default: begin
                st_next.bus = rtc_pkg::RTC_IDLE;
            end
        endcase
        // Answer is prepared in the setup cycle so pready comes from a flop
        if (psel && !penable) begin
            st_next.ready = 1'b1;
            st_next.err   = !rtc_mapped(paddr);
            case (paddr)
                rtc_pkg::REG_EVSEL:  st_next.rdata = st_reg.evsel;
                rtc_pkg::REG_CCFG:   st_next.rdata = st_reg.ccfg;
                rtc_pkg::REG_UOPSEL: st_next.rdata = st_reg.uopsel;
                rtc_pkg::REG_SAMPEN: st_next.rdata = st_reg.sampen;
                rtc_pkg::REG_MATRIX: st_next.rdata = st_reg.matrix;
                rtc_pkg::REG_COUNT:  st_next.rdata = st_reg.count;
                rtc_pkg::REG_STATUS: st_next.rdata = {24'h0, mode_rp, mode_ex,
                                                      mode_fe, mode_comp, st_reg.inc};
                default:             st_next.rdata = 32'h0;
            endcase
        end
        if (acc_done && pwrite) begin
            case (paddr)
                rtc_pkg::REG_EVSEL:  st_next.evsel  = pwdata;
                rtc_pkg::REG_CCFG:   st_next.ccfg   = pwdata;
                rtc_pkg::REG_UOPSEL: st_next.uopsel = pwdata;
                rtc_pkg::REG_SAMPEN: st_next.sampen = pwdata;
                rtc_pkg::REG_MATRIX: st_next.matrix = pwdata;
                rtc_pkg::REG_COUNT:  st_next.count  = pwdata;
                default:             st_next.count  = st_next.count;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '{bus: rtc_pkg::RTC_IDLE, evsel: rtc_pkg::RST_VAL,
                        ccfg: rtc_pkg::RST_VAL, uopsel: rtc_pkg::RST_VAL,
                        sampen: rtc_pkg::RST_VAL, matrix: rtc_pkg::RST_VAL,
                        count: rtc_pkg::RST_VAL, rdata: rtc_pkg::RST_VAL,
                        ready: 1'b0, err: 1'b0, inc: 4'h0, precise: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata      = st_reg.rdata;
    assign pready      = st_reg.ready;
    assign pslverr     = st_reg.err;
    assign evt_inc     = st_reg.inc;
    assign precise_req = st_reg.precise;

    // ======================================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_comp_count_slots: assert property (
        mode_comp |=> evt_inc == $past(rtc_popcount(comp_hit)))
        else $error("completed count wrong");
    a_comp_no_sample: assert property (
        mode_comp |=> !precise_req)
        else $error("precise sample on completed event");
    a_comp_needs_valid: assert property (
        (mode_comp && ret_valid == '0) |=> evt_inc == 4'h0)
        else $error("count without retirement");
    a_fe_tag_count: assert property (
        (mode_fe && !fp_stack_fault) |=> evt_inc == $past(rtc_popcount(fe_hit)))
        else $error("front-end count wrong");
    a_fe_stack_fault: assert property (
        (mode_fe && fp_stack_fault) |=> evt_inc == 4'h0)
        else $error("front-end counted during stack fault");
    a_ex_tag_gate: assert property (
        (mode_ex && !ex_tag_on) |=> evt_inc == 4'h0)
        else $error("execution count without tag");
    a_rp_arm_gate: assert property (
        (mode_rp && !rp_armed) |=> (evt_inc == 4'h0 && !precise_req))
        else $error("replay counted while unarmed");
    a_rp_untagged: assert property (
        (mode_rp && (ret_no_tag | ~ret_valid) == '1) |=> evt_inc == 4'h0)
        else $error("untaggable operation counted");
    a_rp_matrix_off: assert property (
        (mode_rp && st_reg.matrix[4:0] == 5'h0) |=> evt_inc == 4'h0)
        else $error("replay counted with empty matrix");
    a_count_accum: assert property (
        !(psel && penable && pwrite && paddr == rtc_pkg::REG_COUNT) |=>
        st_reg.count == $past(st_reg.count) + {28'h0, evt_inc})
        else $error("counter did not accumulate");
    a_apb_one_wait: assert property (
        (psel && !penable) |=> pready ##1 !pready)
        else $error("pready timing wrong");

    // Mask and class gates, each seen one cycle later at the registered output
    a_comp_mask_spec: assert property (
        (mode_comp && ev_mask[1:0] == 2'b01 && (ret_valid & ~ret_spec) == '0) |=>
        evt_inc == 4'h0)
        else $error("speculative slot counted under non-speculative mask");
    a_idle_no_count: assert property (
        !(mode_comp || mode_fe || mode_ex || mode_rp) |=>
        (evt_inc == 4'h0 && !precise_req))
        else $error("count without a selected event");
    a_precise_replay: assert property (
        !mode_rp |=> !precise_req)
        else $error("precise sample outside replay event");
    a_fe_nonspec_only: assert property (
        (mode_fe && (ret_spec | ~ret_valid) == '1) |=> evt_inc == 4'h0)
        else $error("front-end counted a speculative slot");
    a_ex_needs_match: assert property (
        (mode_ex && (ret_exec_match & ret_valid & ~ret_spec) == '0) |=> evt_inc == 4'h0)
        else $error("execution counted an unmatched slot");
    a_rp_precise_hit: assert property (
        (mode_rp && |rp_hit) |=> precise_req)
        else $error("replay hit without precise sample");

    // Register bus: a write lands at the access edge, the error flag follows the map
    a_apb_err_map: assert property (
        (psel && !penable) |=> pslverr == !$past(rtc_mapped(paddr)))
        else $error("slave error does not follow address map");
    a_evsel_write: assert property (
        (psel && penable && pready && pwrite && paddr == rtc_pkg::REG_EVSEL) |=>
        st_reg.evsel == $past(pwdata))
        else $error("selector write lost");
    a_count_write: assert property (
        (psel && penable && pready && pwrite && paddr == rtc_pkg::REG_COUNT) |=>
        st_reg.count == $past(pwdata))
        else $error("counter load lost");

    c_comp_both: cover property (mode_comp && ev_mask[1:0] == 2'b11 && |ret_spec);
    c_fe_hit: cover property (mode_fe && |fe_hit);
    c_rp_both: cover property (mode_rp && st_reg.matrix[1:0] == 2'b11 && |rp_hit);
    c_slverr: cover property (pready && pslverr);
    c_ex_hit: cover property (mode_ex && |ex_hit);
endmodule
`default_nettype wire

// ===== sim/test_rtc_retire_count.sv
// Self-checking bench for the retirement tagged-event counter.
// Assumes rtc_pkg and rtc_retire_count from core/ are compiled first.
`default_nettype none
module test_rtc_retire_count;
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================================
    // Signals and scoreboard state
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  ret_valid = 3'h0, ret_spec = 3'h0, ret_load = 3'h0, ret_store = 3'h0;
    logic [2:0]  ret_branch = 3'h0, ret_no_tag = 3'h0, ret_exec_match = 3'h0;
    logic [17:0] ret_cause = 18'h0;
    logic        fp_stack_fault = 1'b0;
    logic [3:0]  evt_inc;
    logic        precise_req;
    logic [31:0] ev = 32'h0, cc = 32'h0, uo = 32'h0, se = 32'h0, mx = 32'h0;
    int          fails = 0, samples_checked = 0, cyc = 0, cnt = 0;
    logic [33:0] aq[$];
    logic [37:0] iq[$];
    logic [33:0] an;
    logic [37:0] rn;
    // Cause enables per case, last one lacks the arming bit 24
    logic [31:0] sev[7] = '{32'h0300_0001, 32'h0300_0002, 32'h0300_0004, 32'h0300_0200,
                            32'h0300_0400, 32'h0301_8000, 32'h0200_8004};
    logic [4:0]  mxv[7] = '{5'h01, 5'h01, 5'h03, 5'h01, 5'h02, 5'h10, 5'h13};

    rtc_retire_count dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ret_valid(ret_valid), .ret_spec(ret_spec), .ret_load(ret_load),
        .ret_store(ret_store), .ret_branch(ret_branch), .ret_no_tag(ret_no_tag),
        .ret_exec_match(ret_exec_match), .ret_cause(ret_cause),
        .fp_stack_fault(fp_stack_fault), .evt_inc(evt_inc), .precise_req(precise_req));

    always #20 pclk = ~pclk;
    // ======================================================
    // Reference count for one cycle of retirement slots
    function automatic int model(input logic [2:0] v, s, l, t, b, x, m,
                                 input logic [17:0] c);
        int n;
        logic [5:0] z;
        logic ns, hit, cls;
        n = 0;
        for (int i = 0; i < 3; i++) begin
            z = c[i*6 +: 6];
            ns = v[i] & !s[i];
            hit = (z[0] & se[0]) | (z[1] & se[1]) | (z[2] & se[2]) | (z[3] & se[9])
                | (z[4] & se[10]) | (z[5] & se[15] & se[16]);
            cls = (l[i] & mx[0]) | (t[i] & mx[1]) | (b[i] & mx[4]);
            case ({ev[31:25], cc[15:13]})
                {7'h07, 3'h4}: n += (ns & ev[9]) + (v[i] & s[i] & ev[10]);
                {7'h08, 3'h5}: n += ns & ev[9] & ((l[i] & uo[10]) | (t[i] & uo[11]));
                {7'h0c, 3'h5}: n += ns & ev[9] & uo[24] & uo[4] & (uo[8:5] == 4'h1) & m[i];
                {7'h09, 3'h5}: n += ns & ev[9] & se[24] & se[25] & !x[i] & hit & cls;
                default: ;
            endcase
        end
        return cc[12] ? n : 0;
    endfunction
    // ======================================================
    // Drivers: each notes what it expects
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        aq.push_back({w, err, d});
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            $display("CHECK FAILED %0t no bus answer at %h", $time, a);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cfg(input logic [6:0] code, input logic [15:0] mask, input logic [2:0] sel);
        ev = {code, mask, 9'h0};
        cc = {16'h0, sel, 1'b1, 12'h0};
        apb(1'b1, 8'h00, ev, 1'b0);
        apb(1'b1, 8'h04, cc, 1'b0);
    endtask

    // Random slots for k cycles, then one idle cycle so config writes never count
    task automatic beats(input int k);
        logic [2:0] v, s, l, t, b, x, m;
        logic [17:0] c;
        logic f;
        int e;
        for (int j = 0; j <= k; j++) begin
            {v, s, l, t, b, x, m, c} = (j == k) ? 39'h0 : 39'({$urandom, $urandom});
            f = (j < k) && ($urandom_range(3) == 0);
            e = model(v, s, l, t, b, x, m, c);
            @(posedge pclk);
            ret_valid <= v;
            ret_spec <= s;
            ret_load <= l;
            ret_store <= t;
            ret_branch <= b;
            ret_no_tag <= x;
            ret_exec_match <= m;
            ret_cause <= c;
            fp_stack_fault <= f;
            iq.push_back({cyc, f && ev[31:25] == 7'h08, 4'(e), ev[31:25] == 7'h09 && e > 0});
            cnt += e;
        end
    endtask
    // ======================================================
    // Monitors
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && aq.size() > 0) begin
            an = aq.pop_front();
            samples_checked++;
            if (pslverr !== an[32] || (!an[33] && prdata !== an[31:0])) begin
                fails++;
                $display("CHECK FAILED %0t bus answer at %h", $time, paddr);
            end
        end
    end

    // Front-end undercount during a stack fault is tolerated, never overcount
    always @(negedge pclk) begin
        if (iq.size() > 0 && int'(iq[0][37:6]) < cyc) begin
            rn = iq.pop_front();
            samples_checked++;
            if ((evt_inc !== rn[4:1] && (rn[5] && evt_inc < rn[4:1]) !== 1'b1)
                || precise_req !== rn[0]) begin
                fails++;
                $display("CHECK FAILED %0t count %0d expected %0d", $time, evt_inc, rn[4:1]);
            end
        end
        cyc++;
    end
    // ======================================================
    // Closing and watchdog
    task automatic complete_run;
        $display("Checked %0d, failed %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #(40 * 10000);
        fails++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        complete_run;
    end
    // ======================================================
    // Tests
    initial begin
        void'($urandom(32'h1dd6));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 28; a += 4) apb(1'b0, 8'(a), 32'h0, 1'b0);
        apb(1'b0, 8'h1c, 32'h0, 1'b1);
        apb(1'b1, 8'h1c, 32'h5a5a_5a5a, 1'b1);
        apb(1'b1, 8'h14, 32'h1234_5678, 1'b0);
        apb(1'b0, 8'h14, 32'h1234_5678, 1'b0);
        $display("test registers done");
        apb(1'b1, 8'h14, 32'h0, 1'b0);
        cnt = 0;
        for (int k = 1; k < 4; k++) begin
            cfg(7'h07, 16'(k), 3'h4);
            beats(12);
        end
        cfg(7'h07, 16'h3, 3'h5);
        beats(6);
        apb(1'b0, 8'h14, 32'(cnt), 1'b0);
        $display("test completed done");
        uo = 32'h400;
        apb(1'b1, 8'h08, uo, 1'b0);
        cfg(7'h08, 16'h1, 3'h5);
        beats(16);
        uo = 32'h800;
        apb(1'b1, 8'h08, uo, 1'b0);
        beats(16);
        $display("test front_end done");
        uo = 32'h0100_0030;
        apb(1'b1, 8'h08, uo, 1'b0);
        cfg(7'h0c, 16'h1, 3'h5);
        beats(16);
        uo = 32'h0100_0050;
        apb(1'b1, 8'h08, uo, 1'b0);
        beats(8);
        $display("test execution done");
        cfg(7'h09, 16'h1, 3'h5);
        for (int i = 0; i < 7; i++) begin
            se = sev[i];
            mx = {27'h0, mxv[i]};
            apb(1'b1, 8'h0c, se, 1'b0);
            apb(1'b1, 8'h10, mx, 1'b0);
            beats(12);
        end
        $display("test replay done");
        repeat (3) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 28; a += 4) apb(1'b0, 8'(a), 32'h0, 1'b0);
        $display("test reset done");
        repeat (3) @(posedge pclk);
        complete_run;
    end
endmodule
`default_nettype wire
